//--- core/seq_consts.svh
// Purpose: Constants for the control-word sequencer
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
`define CW_WRITE_BIT 11
`define CW_BITS 12
`define CW_RESET 11'h030
`define RESULT_BITS 12
`define FRAME_CLOCKS 5'd16
`define CAPTURE_CLOCKS 5'd12
`define MUX_SWITCH_CLOCK 5'd14
`define PWR_NORMAL 2'h3
`define PWR_FULL_DOWN 2'h2
`define PWR_AUTO 2'h1
`define SEQ_CONSEC 2'h3
`define SEQ_KEEP 2'h2
`define FIFO_DEPTH 8
`define PINS_RESET 3'h6
`endif

//--- core/seq_pkg.sv
// Purpose: Types shared by the sequencer and its result buffer
// Assumes: Bit 11 of the serial word is the write gate, not stored
// Notes: Field order follows the stored 11-bit word, bit 10 first
package seq_pkg;
  typedef struct packed {
    logic sequencer_mode_high;
    logic [1:0] ignored_bits_hi;
    logic [1:0] channel_select;
    logic [1:0] power_select;
    logic sequencer_mode_low;
    logic ignored_bits_lo;
    logic range_single;
    logic coding_binary;
  } control_word_t;
  typedef struct packed {
    logic [1:0] channel;
    logic [11:0] data;
  } result_word_t;
  typedef enum logic [1:0] {
    FRAME_IDLE,
    FRAME_SHIFT,
    FRAME_DONE
  } frame_state_t;
endpackage

//--- core/result_fifo.sv
// Purpose: Result buffer between the conversion core and the serial output
// Assumes: Single clock, synchronous active-high reset
// Notes: Ready and valid are registered; one push and one pop per cycle
module result_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic rdy_r, rdy_nxt, vld_r, vld_nxt, push, pop;

  always_comb begin
    push = in_valid_in && rdy_r;
    pop = vld_r && out_ready_in;
    wr_nxt = push ? ((wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + PW'(1)) : wr_r;
    rd_nxt = pop ? ((rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + PW'(1)) : rd_r;
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    rdy_nxt = cnt_nxt != CW'(DEPTH);
    vld_nxt = cnt_nxt != '0;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
      vld_r <= 1'b0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
      vld_r <= vld_nxt;
    end
    if (push) begin
      mem_r[wr_r] <= in_data_in;
    end
  end

  assign in_ready_out = rdy_r;
  assign out_valid_out = vld_r;
  assign out_data_out = mem_r[rd_r];
endmodule

//--- core/adc_control_word_sequencer.sv
// Purpose: Serial control-word decoder, channel sequencer and result shifter
// Assumes: Link pins are asynchronous; serial clock well below clk_sys_in / 4
// Notes: Conversion core is outside; it pushes results into the buffer
// Functional notes
// - Write gate bit one loads the eleven bits; zero leaves the word unchanged.
// - Bits 10 and 3 form the sequencer selector, bit 10 upper.
// - Bits 7..6 select next channel or last channel of a sequence.
// - Input multiplexer switches on the fourteenth falling serial edge.
// - Channel of the current result is sent just before its data.
// - Channel address 0..3 maps straight to inputs 0..3.
// - Bits 5 and 4 form the power selector, bit 5 upper.
// - Power selector 11 keeps the converter fully powered always.
// - Power selector 10 powers down until the selector is rewritten.
// - Selector 01 shuts down after each conversion that updated the word.
// - Bit 1 picks input span for next conversion.
// - Bit 0 picks output coding for next conversion.
// - Sequencer upper bit zero: no sequence, channel from last write.
// - Selector 10 changes other fields without disturbing a running sequence.
// - Selector 11 runs channels zero up to the given last channel.
// - Sixteen clocks a frame; first twelve falling edges load, MSB first.
// - Output: two zeros, two channel bits, twelve data bits, falling edges.
`include "seq_consts.svh"

module adc_control_word_sequencer
  import seq_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic din_in,
  output logic dout_out,
  output logic dout_oe_out,
  output logic [1:0] mux_channel_out,
  output logic range_single_out,
  output logic coding_binary_out,
  output logic power_down_out,
  output logic conv_start_out,
  input wire logic result_valid_in,
  input wire logic [`RESULT_BITS-1:0] result_data_in,
  input wire logic [1:0] result_channel_in,
  output logic result_ready_out
);

  function automatic logic [1:0] next_in_sequence(input logic [1:0] cur,
                                                  input logic [1:0] last);
    next_in_sequence = (cur == last) ? 2'h0 : cur + 2'h1;
  endfunction

  // Pin synchronisers: {cs_n, sclk, din}
  logic [2:0] pins_s1_r, pins_s2_r;
  logic sclk_d_r;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pins_s1_r <= `PINS_RESET;
      pins_s2_r <= `PINS_RESET;
      sclk_d_r <= 1'b1;
    end else begin
      pins_s1_r <= {cs_n_in, sclk_in, din_in};
      pins_s2_r <= pins_s1_r;
      sclk_d_r <= pins_s2_r[1];
    end
  end

  logic cs_n_s, sclk_fall, din_s;
  assign cs_n_s = pins_s2_r[2];
  assign din_s = pins_s2_r[0];
  assign sclk_fall = sclk_d_r && !pins_s2_r[1];

  // Result buffer
  result_word_t fifo_in, fifo_out;
  logic fifo_valid, fifo_pop;
  assign fifo_in = '{channel: result_channel_in, data: result_data_in};
  result_fifo #(.WIDTH($bits(result_word_t)), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .in_valid_in(result_valid_in),
    .in_data_in(fifo_in),
    .in_ready_out(result_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_out),
    .out_ready_in(fifo_pop)
  );

  frame_state_t state_r, state_nxt;
  logic [4:0] edge_cnt_r, edge_cnt_nxt;
  logic [`CW_BITS-1:0] rx_sr_r, rx_sr_nxt;
  logic [15:0] tx_sr_r, tx_sr_nxt;
  control_word_t ctrl_r, ctrl_nxt, pend_r, pend_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic seq_act_r, seq_act_nxt;
  logic [1:0] last_r, last_nxt, mux_r, mux_nxt;
  logic dout_r, dout_nxt, oe_r, oe_nxt, pd_r, pd_nxt, start_r, start_nxt;
  logic [4:0] n;
  logic commit, end_conv, frame_start;
  logic [1:0] sel;

  always_comb begin
    state_nxt = state_r;
    edge_cnt_nxt = edge_cnt_r;
    rx_sr_nxt = rx_sr_r;
    tx_sr_nxt = tx_sr_r;
    ctrl_nxt = ctrl_r;
    pend_nxt = pend_r;
    wr_pend_nxt = wr_pend_r;
    seq_act_nxt = seq_act_r;
    last_nxt = last_r;
    mux_nxt = mux_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    pd_nxt = pd_r;
    start_nxt = 1'b0;
    fifo_pop = 1'b0;
    commit = 1'b0;
    end_conv = 1'b0;
    frame_start = 1'b0;
    n = edge_cnt_r + 5'd1;
    sel = {pend_r.sequencer_mode_high, pend_r.sequencer_mode_low};
    case (state_r)
      FRAME_IDLE: begin
        if (!cs_n_s) begin
          frame_start = 1'b1;
          state_nxt = FRAME_SHIFT;
          edge_cnt_nxt = '0;
          wr_pend_nxt = 1'b0;
          fifo_pop = fifo_valid;
          // Empty buffer sends zeros rather than stale data
          tx_sr_nxt = fifo_valid ? {2'b00, fifo_out.channel, fifo_out.data} : '0;
          dout_nxt = 1'b0;
          oe_nxt = 1'b1;
          start_nxt = 1'b1;
        end
      end
      FRAME_SHIFT: begin
        if (cs_n_s) begin
          state_nxt = FRAME_IDLE;
          oe_nxt = 1'b0;
        end else if (sclk_fall) begin
          edge_cnt_nxt = n;
          tx_sr_nxt = {tx_sr_r[14:0], 1'b0};
          dout_nxt = tx_sr_r[14];
          if (n <= `CAPTURE_CLOCKS) begin
            rx_sr_nxt = {rx_sr_r[`CW_BITS-2:0], din_s};
          end
          if (n == `CAPTURE_CLOCKS) begin
            wr_pend_nxt = rx_sr_r[`CW_WRITE_BIT-1];
            pend_nxt = control_word_t'({rx_sr_r[`CW_BITS-3:0], din_s});
          end
          if (n == `MUX_SWITCH_CLOCK) begin
            commit = 1'b1;
          end
          if (n == `FRAME_CLOCKS) begin
            end_conv = 1'b1;
            state_nxt = FRAME_DONE;
          end
        end
      end
      FRAME_DONE: begin
        if (cs_n_s) begin
          state_nxt = FRAME_IDLE;
          oe_nxt = 1'b0;
          dout_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = FRAME_IDLE;
      end
    endcase
    if (commit) begin
      if (wr_pend_r) begin
        ctrl_nxt = pend_r;
        if (sel == `SEQ_CONSEC) begin
          seq_act_nxt = 1'b1;
          last_nxt = pend_r.channel_select;
          mux_nxt = 2'h0;
        end else if (sel == `SEQ_KEEP) begin
          mux_nxt = seq_act_r ? next_in_sequence(mux_r, last_r)
                              : pend_r.channel_select;
        end else begin
          seq_act_nxt = 1'b0;
          mux_nxt = pend_r.channel_select;
        end
      end else if (seq_act_r) begin
        mux_nxt = next_in_sequence(mux_r, last_r);
      end
    end
    case (ctrl_nxt.power_select)
      `PWR_NORMAL: pd_nxt = 1'b0;
      `PWR_FULL_DOWN: pd_nxt = 1'b1;
      `PWR_AUTO: begin
        if (end_conv && wr_pend_r) begin
          pd_nxt = 1'b1;
        end else if (frame_start) begin
          pd_nxt = 1'b0;
        end
      end
      default: pd_nxt = pd_r;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_r <= FRAME_IDLE;
      edge_cnt_r <= '0;
      rx_sr_r <= '0;
      tx_sr_r <= '0;
      ctrl_r <= control_word_t'(`CW_RESET);
      pend_r <= control_word_t'(`CW_RESET);
      wr_pend_r <= 1'b0;
      seq_act_r <= 1'b0;
      last_r <= 2'h0;
      mux_r <= 2'h0;
      dout_r <= 1'b0;
      oe_r <= 1'b0;
      pd_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      rx_sr_r <= rx_sr_nxt;
      tx_sr_r <= tx_sr_nxt;
      ctrl_r <= ctrl_nxt;
      pend_r <= pend_nxt;
      wr_pend_r <= wr_pend_nxt;
      seq_act_r <= seq_act_nxt;
      last_r <= last_nxt;
      mux_r <= mux_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      pd_r <= pd_nxt;
      start_r <= start_nxt;
    end
  end

  assign dout_out = dout_r;
  assign dout_oe_out = oe_r;
  assign mux_channel_out = mux_r;
  assign range_single_out = ctrl_r.range_single;
  assign coding_binary_out = ctrl_r.coding_binary;
  assign power_down_out = pd_r;
  assign conv_start_out = start_r;

  property p_gate_hold;
    @(posedge clk_sys_in) disable iff (reset_in)
      (commit && !wr_pend_r) |=> $stable(ctrl_r);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("word changed without gate");

  property p_word_only_on_commit;
    @(posedge clk_sys_in) disable iff (reset_in)
      $changed(ctrl_r) |-> $past(commit) && $past(wr_pend_r);
  endproperty
  a_word_only_on_commit: assert property (p_word_only_on_commit) else $error("bad word load");

  property p_mux_on_14th;
    @(posedge clk_sys_in) disable iff (reset_in)
      $changed(mux_r) |-> $past(commit) && $past(edge_cnt_r) == 5'd13;
  endproperty
  a_mux_on_14th: assert property (p_mux_on_14th) else $error("mux moved off edge 14");

  property p_chan_before_data;
    @(posedge clk_sys_in) disable iff (reset_in)
      (frame_start && fifo_valid) |=> tx_sr_r[15:12] == {2'b00, $past(fifo_out.channel)};
  endproperty
  a_chan_before_data: assert property (p_chan_before_data) else $error("bad header");

  property p_normal_up;
    @(posedge clk_sys_in) disable iff (reset_in)
      (ctrl_r.power_select == `PWR_NORMAL) [*2] |-> !pd_r;
  endproperty
  a_normal_up: assert property (p_normal_up) else $error("down in normal mode");

  property p_full_down;
    @(posedge clk_sys_in) disable iff (reset_in)
      (ctrl_r.power_select == `PWR_FULL_DOWN) |-> pd_r;
  endproperty
  a_full_down: assert property (p_full_down) else $error("up in shutdown mode");

  property p_auto_down;
    @(posedge clk_sys_in) disable iff (reset_in)
      (end_conv && wr_pend_r && ctrl_r.power_select == `PWR_AUTO) |=> pd_r;
  endproperty
  a_auto_down: assert property (p_auto_down) else $error("no auto shutdown");

  property p_seq_start;
    @(posedge clk_sys_in) disable iff (reset_in)
      (commit && wr_pend_r && sel == `SEQ_CONSEC) |=> mux_r == 2'h0 && seq_act_r;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("sequence not started");

  property p_no_seq;
    @(posedge clk_sys_in) disable iff (reset_in)
      (commit && wr_pend_r && !sel[1]) |=> !seq_act_r && mux_r == $past(pend_r.channel_select);
  endproperty
  a_no_seq: assert property (p_no_seq) else $error("plain channel wrong");

  property p_wrap;
    @(posedge clk_sys_in) disable iff (reset_in)
      (commit && !wr_pend_r && seq_act_r && mux_r == last_r) |=> mux_r == 2'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("sequence did not wrap");

  c_write: cover property (@(posedge clk_sys_in) disable iff (reset_in) commit && wr_pend_r);
  c_wrap: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    commit && seq_act_r && mux_r == last_r && last_r != 2'h0);
  c_auto: cover property (@(posedge clk_sys_in) disable iff (reset_in) end_conv ##1 pd_r);
endmodule

//--- test/host_master_model.sv
// Purpose: Serial master standing in for the host controller
// Assumes: Link clock idles high between frames; 160 ns period
// Notes: The bench starts each frame through the frame task
module host_master_model (
  input wire logic clk_sys_in,
  input wire logic dout_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic din_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 16;
  initial begin
    cs_n_out = 1'h1;
    sclk_out = 1'h1;
    din_out = 1'h0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // Fewer than sixteen falls cuts the frame short
  task automatic frame(input logic [11:0] word, input int falls, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n_out <= 1'h0;
    wait_clk(HALF);
    for (int i = 0; i < falls; i++) begin
      din_out <= (i < 12) ? word[11-i] : ~din_out;
      wait_clk(HALF);
      rx[15-i] = dout_in;
      sclk_out <= 1'h0;
      wait_clk(HALF);
      sclk_out <= 1'h1;
    end
    wait_clk(HALF);
    cs_n_out <= 1'h1;
    din_out <= ~din_out;
    wait_clk(8);
  endtask
endmodule

//--- test/testbench.sv
// Purpose: Self-checking bench for the control-word sequencer
// Assumes: Bench acts as the conversion core and pushes results
// Notes: Status is compared as one packed word after each frame in s_select, s_power and s_seq
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import seq_pkg::*;
  logic clk_sys_in;
  logic reset_in;
  logic cs_n, sclk, din, dout, dout_oe, rng, cod, pdn, cstart;
  logic [1:0] mux;
  logic rvalid, rready;
  logic [11:0] rdata;
  logic [1:0] rch;
  logic [15:0] rx;
  int fails = 0;
  int tests_run = 0;
  int starts = 0;
  int oe_cycles = 0;

  // Counts start pulses and cycles with the output driven
  always @(posedge clk_sys_in) begin
    if (cstart === 1'h1) begin
      starts++;
    end
    if (dout_oe === 1'h1) begin
      oe_cycles++;
    end
  end

  adc_control_word_sequencer dut_u (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .cs_n_in(cs_n),
    .sclk_in(sclk),
    .din_in(din),
    .dout_out(dout),
    .dout_oe_out(dout_oe),
    .mux_channel_out(mux),
    .range_single_out(rng),
    .coding_binary_out(cod),
    .power_down_out(pdn),
    .conv_start_out(cstart),
    .result_valid_in(rvalid),
    .result_data_in(rdata),
    .result_channel_in(rch),
    .result_ready_out(rready)
  );
  host_master_model host_u (
    .clk_sys_in(clk_sys_in),
    .dout_in(dout),
    .cs_n_out(cs_n),
    .sclk_out(sclk),
    .din_out(din)
  );

  initial begin
    clk_sys_in = 1'h0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic report_and_stop();
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Unused bits are sent as ones so that any use of them shows
  function automatic logic [11:0] cw(logic g, logic [1:0] sq, logic [1:0] ch, logic [1:0] pm,
                                     logic rg, logic cd);
    return {g, sq[1], 2'h3, ch, pm, sq[0], 1'h1, rg, cd};
  endfunction
  function automatic logic [15:0] stat();
    return {10'h000, dout_oe, mux, rng, cod, pdn};
  endfunction
  function automatic logic [15:0] est(logic [1:0] ch, logic rg, logic cd, logic pd);
    return {11'h000, ch, rg, cd, pd};
  endfunction

  task automatic xfer(input logic [11:0] w, input logic [15:0] exp);
    host_u.frame(w, 16, rx);
    chk(stat(), exp, "status");
  endtask

  task automatic s_reset();
    int s0;
    int o0;
    chk(stat(), est(2'h0, 1'h0, 1'h0, 1'h0), "reset status");
    chk({15'h0000, rready}, 16'h0001, "ready after reset");
    s0 = starts;
    o0 = oe_cycles;
    host_u.frame(cw(1'h0, 2'h0, 2'h0, 2'h3, 1'h0, 1'h0), 16, rx);
    chk(rx, 16'h0000, "empty buffer word");
    chk(16'(starts - s0), 16'h0001, "start pulses");
    // Drive lasts as long as chip select is low: 34 link half periods of 16 clocks
    chk(16'(oe_cycles - o0), 16'h0220, "drive cycles");
  endtask

  task automatic s_select();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      xfer(cw(1'h1, 2'h0, c, 2'h3, c[0], c[1]), est(c, c[0], c[1], 1'h0));
    end
    xfer(cw(1'h0, 2'h0, 2'h1, 2'h3, 1'h0, 1'h0), est(2'h3, 1'h1, 1'h1, 1'h0));
    host_u.frame(cw(1'h1, 2'h0, 2'h0, 2'h3, 1'h0, 1'h0), 13, rx);
    chk(stat(), est(2'h3, 1'h1, 1'h1, 1'h0), "short frame");
  endtask

  // Every word sent keeps the power selector away from zero
  task automatic s_power();
    xfer(cw(1'h1, 2'h0, 2'h3, 2'h2, 1'h0, 1'h0), est(2'h3, 1'h0, 1'h0, 1'h1));
    xfer(cw(1'h0, 2'h0, 2'h3, 2'h3, 1'h0, 1'h0), est(2'h3, 1'h0, 1'h0, 1'h1));
    xfer(cw(1'h1, 2'h0, 2'h3, 2'h3, 1'h0, 1'h0), est(2'h3, 1'h0, 1'h0, 1'h0));
    xfer(cw(1'h1, 2'h0, 2'h3, 2'h1, 1'h0, 1'h0), est(2'h3, 1'h0, 1'h0, 1'h1));
    host_u.wait_clk(200);
    xfer(cw(1'h0, 2'h0, 2'h3, 2'h1, 1'h0, 1'h0), est(2'h3, 1'h0, 1'h0, 1'h0));
    xfer(cw(1'h1, 2'h0, 2'h3, 2'h3, 1'h0, 1'h0), est(2'h3, 1'h0, 1'h0, 1'h0));
  endtask

  task automatic s_seq();
    xfer(cw(1'h1, 2'h3, 2'h2, 2'h3, 1'h0, 1'h0), est(2'h0, 1'h0, 1'h0, 1'h0));
    for (int i = 1; i < 5; i++) begin
      xfer(cw(1'h0, 2'h0, 2'h0, 2'h3, 1'h0, 1'h0), est(2'(i % 3), 1'h0, 1'h0, 1'h0));
    end
    xfer(cw(1'h1, 2'h2, 2'h2, 2'h3, 1'h1, 1'h0), est(2'h2, 1'h1, 1'h0, 1'h0));
    xfer(cw(1'h1, 2'h0, 2'h3, 2'h3, 1'h0, 1'h0), est(2'h3, 1'h0, 1'h0, 1'h0));
    xfer(cw(1'h1, 2'h1, 2'h1, 2'h3, 1'h0, 1'h0), est(2'h1, 1'h0, 1'h0, 1'h0));
    xfer(cw(1'h0, 2'h0, 2'h2, 2'h3, 1'h0, 1'h0), est(2'h1, 1'h0, 1'h0, 1'h0));
  endtask

  task automatic push(input logic [1:0] ch, input logic [11:0] data);
    int n;
    n = 0;
    rvalid <= 1'h1;
    rch <= ch;
    rdata <= data;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (rready !== 1'h1 && n < 50);
    if (rready !== 1'h1) begin
      fails++;
      $display("CHECK FAILED at %0t: result push timed out", $time);
      report_and_stop();
    end
  endtask

  // Fill the buffer until it refuses, then drain it frame by frame
  task automatic s_results();
    @(posedge clk_sys_in);
    for (int i = 0; i < 8; i++) begin
      push(2'(i), 12'ha50 + 12'(i));
    end
    rvalid <= 1'h0;
    host_u.wait_clk(2);
    chk({15'h0000, rready}, 16'h0000, "buffer full");
    for (int i = 0; i < 8; i++) begin
      host_u.frame(cw(1'h0, 2'h0, 2'h0, 2'h3, 1'h0, 1'h0), 16, rx);
      chk(rx, {2'h0, 2'(i), 12'ha50 + 12'(i)}, "result word");
    end
    host_u.frame(cw(1'h0, 2'h0, 2'h0, 2'h3, 1'h0, 1'h0), 16, rx);
    chk(rx, 16'h0000, "drained word");
    chk({15'h0000, rready}, 16'h0001, "buffer empty");
  endtask

  initial begin
    reset_in = 1'h1;
    rvalid = 1'h0;
    rdata = 12'h000;
    rch = 2'h0;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'h0;
    repeat (4) @(posedge clk_sys_in);
    s_reset();
    s_select();
    s_power();
    s_seq();
    s_results();
    report_and_stop();
  end
endmodule
